// ---- hw/handler_ctrl_pkg.sv ----
/*
   Constants, field layouts and carriers for the system handler control
   and state block. Assumes a single core clock domain.
*/
package handler_ctrl_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   localparam logic [11:0] CS_OFFSET = 12'hD24;
   localparam logic [11:0] STATUS_OFFSET = 12'hD40;
   localparam logic [11:0] MASK_OFFSET = 12'hD44;

   localparam int BUS_EN_BIT = 17;
   localparam int MEM_EN_BIT = 16;
   localparam int CALL_PEND_BIT = 15;
   localparam int BUS_PEND_BIT = 14;
   localparam int MEM_PEND_BIT = 13;
   localparam int USAGE_PEND_BIT = 12;
   localparam int TICK_ACT_BIT = 11;
   localparam int DEFER_ACT_BIT = 10;
   localparam int DEBUG_ACT_BIT = 8;
   localparam int CALL_ACT_BIT = 7;
   localparam int USAGE_ACT_BIT = 3;
   localparam int BUS_ACT_BIT = 1;

   localparam logic [31:0] CS_WRITE_MASK = 32'h0003_FD8A;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   localparam int PEND_CALL = 3;
   localparam int PEND_BUS = 2;
   localparam int PEND_MEM = 1;
   localparam int PEND_USAGE = 0;

   localparam int ACT_TICK = 5;
   localparam int ACT_DEFER = 4;
   localparam int ACT_DEBUG = 3;
   localparam int ACT_CALL = 2;
   localparam int ACT_USAGE = 1;
   localparam int ACT_BUS = 0;

   localparam int EV_W = 4;
   localparam int EV_BUS_TAKEN = 0;
   localparam int EV_MEM_TAKEN = 1;
   localparam int EV_ESCALATED = 2;
   localparam int EV_CONTEXT = 3;
   localparam logic [3:0] EVENT_RESET = 4'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] pend_set;
      logic [3:0] pend_clr;
      logic [5:0] act_set;
      logic [5:0] act_clr;
   } core_update_s;

   typedef struct packed {
      logic bus;
      logic mem;
      logic usage;
   } fault_req_s;

   typedef struct packed {
      logic bus_enable;
      logic mem_enable;
      logic [3:0] pending;
      logic [5:0] active;
   } handler_state_s;

   localparam handler_state_s STATE_RESET = '0;

   typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;
   typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_e;

endpackage

// ---- hw/system_handler_ctrl_state.sv ----
/*
   System handler control and state register with an AXI4-Lite slave,
   fault routing to handler or hard fault, and a masked event interrupt.
   Assumes the core exception logic and the bus share core_clk.
*/
`timescale 1ns/10ps
module system_handler_ctrl_state
   import handler_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core exception logic.
   input wire core_update_s core_update,
   input wire fault_req_s fault_req,
   input wire logic stack_adjusted,
   output handler_state_s handler_state,
   output logic bus_fault_take,
   output logic mem_fault_take,
   output logic hard_fault_take,
   output logic context_fault,
   // Interrupt.
   output logic irq
);

   function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            m[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic [31:0] state_to_word(input handler_state_s s);
      logic [31:0] w;
      w = WORD_ZERO;
      w[BUS_EN_BIT] = s.bus_enable;
      w[MEM_EN_BIT] = s.mem_enable;
      w[CALL_PEND_BIT] = s.pending[PEND_CALL];
      w[BUS_PEND_BIT] = s.pending[PEND_BUS];
      w[MEM_PEND_BIT] = s.pending[PEND_MEM];
      w[USAGE_PEND_BIT] = s.pending[PEND_USAGE];
      w[TICK_ACT_BIT] = s.active[ACT_TICK];
      w[DEFER_ACT_BIT] = s.active[ACT_DEFER];
      w[DEBUG_ACT_BIT] = s.active[ACT_DEBUG];
      w[CALL_ACT_BIT] = s.active[ACT_CALL];
      w[USAGE_ACT_BIT] = s.active[ACT_USAGE];
      w[BUS_ACT_BIT] = s.active[ACT_BUS];
      return w;
   endfunction

   function automatic handler_state_s word_to_state(input logic [31:0] w);
      handler_state_s s;
      s.bus_enable = w[BUS_EN_BIT];
      s.mem_enable = w[MEM_EN_BIT];
      s.pending = {w[CALL_PEND_BIT], w[BUS_PEND_BIT], w[MEM_PEND_BIT], w[USAGE_PEND_BIT]};
      s.active = {w[TICK_ACT_BIT], w[DEFER_ACT_BIT], w[DEBUG_ACT_BIT],
                  w[CALL_ACT_BIT], w[USAGE_ACT_BIT], w[BUS_ACT_BIT]};
      return s;
   endfunction

   wr_state_e wr_state;
   rd_state_e rd_state;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [STRB_W-1:0] wstrb_q;
   logic [EV_W-1:0] event_status;
   logic [EV_W-1:0] event_mask;
   logic rd_cs_q;

   // Bus handshakes.
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire b_fire = s_axi_bvalid & s_axi_bready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire r_fire = s_axi_rvalid & s_axi_rready;
   wire next_aw_held = aw_fire | (aw_held & ~b_fire);
   wire next_w_held = w_fire | (w_held & ~b_fire);
   wire wr_go = aw_held & w_held & (wr_state == WR_IDLE);
   wire rd_done = (rd_state == RD_DATA) & r_fire;
   wire next_rd_busy = ar_fire | ((rd_state == RD_DATA) & ~r_fire);

   // Address decode.
   wire wr_cs = wr_go & (aw_addr_q == CS_OFFSET);
   wire wr_mask = wr_go & (aw_addr_q == MASK_OFFSET);
   wire wr_hit = wr_cs | wr_mask | (aw_addr_q == STATUS_OFFSET);
   wire rd_is_cs = s_axi_araddr == CS_OFFSET;
   wire rd_is_status = s_axi_araddr == STATUS_OFFSET;
   wire rd_is_mask = s_axi_araddr == MASK_OFFSET;
   wire rd_hit = rd_is_cs | rd_is_status | rd_is_mask;
   wire status_clr = ar_fire & rd_is_status;

   // Fault routing uses the enables as they stand this cycle.
   wire bus_taken = fault_req.bus & handler_state.bus_enable;
   wire mem_taken = fault_req.mem & handler_state.mem_enable;
   wire escalate = (fault_req.bus & ~handler_state.bus_enable)
                 | (fault_req.mem & ~handler_state.mem_enable);

   // Hardware update: a set from the core beats a clear in the same cycle.
   wire [3:0] hw_pend_set = core_update.pend_set
                          | {1'b0, bus_taken, mem_taken, fault_req.usage};
   wire [3:0] hw_pending = (handler_state.pending & ~core_update.pend_clr)
                         | hw_pend_set;
   wire [5:0] hw_active = (handler_state.active & ~core_update.act_clr)
                        | core_update.act_set;
   wire handler_state_s hw_state = '{bus_enable: handler_state.bus_enable,
                                     mem_enable: handler_state.mem_enable,
                                     pending: hw_pending,
                                     active: hw_active};

   // Strobed bytes come from software, the rest from the hardware update.
   wire [31:0] cs_merged = byte_merge(state_to_word(hw_state), wdata_q, wstrb_q)
                         & CS_WRITE_MASK;
   wire handler_state_s sw_state = word_to_state(cs_merged);
   wire handler_state_s next_state = wr_cs ? sw_state : hw_state;

   // The core cannot see a stack fix-up, so an unaided active change is flagged.
   wire next_context = wr_cs & (sw_state.active != handler_state.active)
                     & ~stack_adjusted;

   wire [EV_W-1:0] events = {next_context, escalate, mem_taken, bus_taken};
   wire [EV_W-1:0] next_status = (event_status & ~{EV_W{status_clr}}) | events;
   wire [31:0] mask_merged = byte_merge({28'h0, event_mask}, wdata_q, wstrb_q);
   wire [EV_W-1:0] next_mask = wr_mask ? mask_merged[EV_W-1:0] : event_mask;

   wire [31:0] rd_word = rd_is_cs ? state_to_word(handler_state)
                       : rd_is_status ? {28'h0, event_status}
                       : rd_is_mask ? {28'h0, event_mask} : WORD_ZERO;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         handler_state <= STATE_RESET;
         event_status <= EVENT_RESET;
         event_mask <= EVENT_RESET;
         irq <= 1'b0;
         bus_fault_take <= 1'b0;
         mem_fault_take <= 1'b0;
         hard_fault_take <= 1'b0;
         context_fault <= 1'b0;
      end
      else
      begin
         handler_state <= next_state;
         event_status <= next_status;
         event_mask <= next_mask;
         irq <= |(next_status & next_mask);
         bus_fault_take <= bus_taken;
         mem_fault_take <= mem_taken;
         hard_fault_take <= escalate;
         context_fault <= next_context;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_addr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= ~next_aw_held;
         s_axi_wready <= ~next_w_held;
         if (aw_fire)
         begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_fire)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wr_state <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         case (wr_state)
            WR_IDLE:
            begin
               if (wr_go)
               begin
                  wr_state <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
               end
            end
            WR_RESP:
            begin
               if (b_fire)
               begin
                  wr_state <= WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default:
            begin
               wr_state <= WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= WORD_ZERO;
         s_axi_rresp <= RESP_OKAY;
         rd_cs_q <= 1'b0;
      end
      else
      begin
         s_axi_arready <= ~next_rd_busy;
         case (rd_state)
            RD_IDLE:
            begin
               if (ar_fire)
               begin
                  rd_state <= RD_DATA;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_word;
                  s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                  rd_cs_q <= rd_is_cs;
               end
            end
            RD_DATA:
            begin
               if (rd_done)
               begin
                  rd_state <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default:
            begin
               rd_state <= RD_IDLE;
               s_axi_rvalid <= 1'b0;
            end
         endcase
      end
   end

   chk_bus_fault_take: assert property (
      @(posedge core_clk) disable iff (reset)
      fault_req.bus && handler_state.bus_enable
      && (handler_state.mem_enable || !fault_req.mem)
      |=> bus_fault_take && !hard_fault_take)
      else $error("enabled bus fault not taken");
   chk_fault_escalate: assert property (
      @(posedge core_clk) disable iff (reset)
      (fault_req.mem && !handler_state.mem_enable) |=> hard_fault_take && !mem_fault_take)
      else $error("disabled fault not escalated");
   chk_mem_enable_write: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_cs && wstrb_q[2] |=> handler_state.mem_enable == $past(wdata_q[MEM_EN_BIT]))
      else $error("memory fault enable write lost");
   chk_pending_read: assert property (
      @(posedge core_clk) disable iff (reset)
      ar_fire && rd_is_cs |=> s_axi_rdata[15:12] == $past(handler_state.pending))
      else $error("pending bits read wrong");
   chk_pending_track: assert property (
      @(posedge core_clk) disable iff (reset)
      !wr_cs && (core_update.pend_set[PEND_CALL] || fault_req.usage)
      |=> handler_state.pending[PEND_CALL] || handler_state.pending[PEND_USAGE])
      else $error("pending set from core lost");
   chk_active_clear: assert property (
      @(posedge core_clk) disable iff (reset)
      !wr_cs && core_update.act_clr[ACT_DEFER] && !core_update.act_set[ACT_DEFER]
      |=> !handler_state.active[ACT_DEFER])
      else $error("active clear from core lost");
   chk_active_write: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_cs && wstrb_q[0] && wstrb_q[1]
      |=> handler_state.active[ACT_DEBUG] == $past(wdata_q[DEBUG_ACT_BIT])
          && handler_state.active[ACT_CALL] == $past(wdata_q[CALL_ACT_BIT])
          && handler_state.active[ACT_USAGE] == $past(wdata_q[USAGE_ACT_BIT]))
      else $error("active bits write lost");
   chk_write_wins: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_cs && wstrb_q[0] && core_update.act_set[ACT_BUS] && !wdata_q[BUS_ACT_BIT]
      |=> !handler_state.active[ACT_BUS])
      else $error("software write did not win");
   chk_reserved_zero: assert property (
      @(posedge core_clk) disable iff (reset)
      s_axi_rvalid && rd_cs_q |-> (s_axi_rdata & ~CS_WRITE_MASK) == WORD_ZERO)
      else $error("reserved bits read nonzero");
   chk_context_flag: assert property (
      @(posedge core_clk) disable iff (reset)
      wr_cs && !stack_adjusted && (sw_state.active != handler_state.active)
      |=> context_fault ##1 event_status[EV_CONTEXT] || status_clr)
      else $error("context fault not raised");
   chk_bresp_hold: assert property (
      @(posedge core_clk) disable iff (reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

endmodule

// ---- testbench/system_handler_ctrl_state_tb_top.sv ----
/*
   Self-checking bench for the system handler control and state block.
   Assumes the design package and the design module are compiled before it.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("mismatch %s expected %h seen %h", nm, (exp), (got)); \
      end \
   end

module system_handler_ctrl_state_tb_top;
   import handler_ctrl_pkg::*;

   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [DATA_W-1:0] s_axi_wdata = '0;
   logic [STRB_W-1:0] s_axi_wstrb = '0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [DATA_W-1:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   core_update_s core_update = '0;
   fault_req_s fault_req = '0;
   logic stack_adjusted = 1'b1;
   handler_state_s handler_state;
   logic bus_fault_take;
   logic mem_fault_take;
   logic hard_fault_take;
   logic context_fault;
   logic irq;
   int err_total = 0;
   int n_tests = 0;
   int cs_bits[12] = '{17, 16, 15, 14, 13, 12, 11, 10, 8, 7, 3, 1};
   core_update_s upd;
   logic [31:0] rmw;
   logic [1:0] rr;

   system_handler_ctrl_state dut_u (
      .core_clk(core_clk), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .core_update(core_update), .fault_req(fault_req), .stack_adjusted(stack_adjusted),
      .handler_state(handler_state), .bus_fault_take(bus_fault_take),
      .mem_fault_take(mem_fault_take), .hard_fault_take(hard_fault_take),
      .context_fault(context_fault), .irq(irq)
   );

   always #5 core_clk = ~core_clk;

   // Values read right after an edge are the ones the design sampled there,
   // since every design output is updated by non-blocking assignment.
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (s_axi_bvalid !== 1'b1)
      begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (s_axi_rvalid !== 1'b1)
      begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      axi_write(a, d, r);
      `CHK("bresp", er, r)
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [1:0] r;
      logic [31:0] d;
      axi_read(a, d, r);
      `CHK("rresp", er, r)
      `CHK("rdata", ed, d)
   endtask

   // The take pulses last one cycle, so they are looked at just after the
   // edge that samples the request.
   task automatic core_pulse(input core_update_s u, input fault_req_s f);
      @(posedge core_clk);
      core_update <= u;
      fault_req <= f;
      @(posedge core_clk);
      core_update <= '0;
      fault_req <= '0;
      #1;
   endtask

   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      $display("watchdog expired");
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      rd(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      `CHK("handler_state", STATE_RESET, handler_state)
      `CHK("irq", 1'b0, irq)
      $display("test reset values done");

      wr(CS_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
      rd(CS_OFFSET, CS_WRITE_MASK, RESP_OKAY);
      `CHK("handler_state", 12'hFFF, handler_state)
      wr(CS_OFFSET, 32'h0000_0274, RESP_OKAY);
      rd(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      foreach (cs_bits[i])
      begin
         wr(CS_OFFSET, 32'h0000_0001 << cs_bits[i], RESP_OKAY);
         rd(CS_OFFSET, 32'h0000_0001 << cs_bits[i], RESP_OKAY);
      end
      $display("test software access done");

      // Reversed bit table: entries 0 to 5 are active bits, 6 to 9 pending bits.
      wr(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      for (int j = 0; j < 10; j++)
      begin
         upd = '0;
         if (j < 6)
            upd.act_set = 6'h01 << j;
         else
            upd.pend_set = 4'h1 << (j - 6);
         core_pulse(upd, '0);
         rd(CS_OFFSET, 32'h0000_0001 << cs_bits[11 - j], RESP_OKAY);
         core_pulse({4'h0, upd.pend_set, 6'h00, upd.act_set}, '0);
         rd(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      end
      $display("test core tracking done");

      wr(MASK_OFFSET, 32'h0000_000F, RESP_OKAY);
      rd(MASK_OFFSET, 32'h0000_000F, RESP_OKAY);
      wr(CS_OFFSET, 32'h0003_0000, RESP_OKAY);
      core_pulse('0, 3'b100);
      `CHK("bus_fault_take", 1'b1, bus_fault_take)
      `CHK("hard_fault_take", 1'b0, hard_fault_take)
      core_pulse('0, 3'b010);
      `CHK("mem_fault_take", 1'b1, mem_fault_take)
      core_pulse('0, 3'b001);
      `CHK("usage_pending", 1'b1, handler_state.pending[PEND_USAGE])
      settle();
      `CHK("irq", 1'b1, irq)
      rd(STATUS_OFFSET, 32'h0000_0003, RESP_OKAY);
      rd(CS_OFFSET, 32'h0003_7000, RESP_OKAY);
      settle();
      `CHK("irq", 1'b0, irq)
      wr(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      core_pulse('0, 3'b100);
      `CHK("hard_fault_take", 1'b1, hard_fault_take)
      `CHK("bus_fault_take", 1'b0, bus_fault_take)
      core_pulse('0, 3'b010);
      `CHK("hard_fault_take", 1'b1, hard_fault_take)
      `CHK("mem_fault_take", 1'b0, mem_fault_take)
      rd(STATUS_OFFSET, 32'h0000_0004, RESP_OKAY);
      wr(MASK_OFFSET, WORD_ZERO, RESP_OKAY);
      core_pulse('0, 3'b100);
      settle();
      `CHK("irq", 1'b0, irq)
      rd(STATUS_OFFSET, 32'h0000_0004, RESP_OKAY);
      $display("test fault routing done");

      stack_adjusted <= 1'b0;
      wr(CS_OFFSET, 32'h0000_0800, RESP_OKAY);
      `CHK("context_fault", 1'b1, context_fault)
      rd(STATUS_OFFSET, 32'h0000_0008, RESP_OKAY);
      // Active bits are only changed again with the stack fix-up in place.
      stack_adjusted <= 1'b1;
      wr(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      `CHK("context_fault", 1'b0, context_fault)
      wr(STATUS_OFFSET, 32'h0000_000F, RESP_OKAY);
      rd(STATUS_OFFSET, WORD_ZERO, RESP_OKAY);
      $display("test context fault done");

      // Software changes one bit by read-modify-write, so the rest survives.
      upd = '0;
      upd.pend_set = 4'h8;
      core_pulse(upd, '0);
      axi_read(CS_OFFSET, rmw, rr);
      wr(CS_OFFSET, rmw | 32'h0002_0000, RESP_OKAY);
      rd(CS_OFFSET, 32'h0002_8000, RESP_OKAY);
      // The core sets the bus active bit in the very cycle the write lands.
      upd = '0;
      upd.act_set = 6'h01;
      fork
         wr(CS_OFFSET, 32'h0003_0000, RESP_OKAY);
         begin
            repeat (2) @(posedge core_clk);
            core_update <= upd;
            @(posedge core_clk);
            core_update <= '0;
         end
      join
      rd(CS_OFFSET, 32'h0003_0000, RESP_OKAY);
      wr(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      $display("test write precedence done");

      wr(12'h100, 32'hFFFF_FFFF, RESP_SLVERR);
      rd(12'h100, WORD_ZERO, RESP_SLVERR);
      rd(12'hD26, WORD_ZERO, RESP_SLVERR);
      rd(CS_OFFSET, WORD_ZERO, RESP_OKAY);
      $display("test unmapped access done");
      tally_and_finish();
   end
endmodule
